// file: core/mri_pkg.sv
// constants, types and register map of the motor restart inhibit block
package mri_pkg;

  localparam int          CUR_W        = 16;
  localparam int          SLOTS        = 20;   // most starts ever counted
  localparam logic [4:0]  MAX_LO       = 5'h01;
  localparam logic [4:0]  MAX_HI       = 5'h14;
  localparam logic [9:0]  IVL_HI       = 10'h3E8; // 100.0 min in tenths
  localparam int          PCT_LOW      = 10;   // stop level, percent of nominal

  // timebase: one tick every 0.1 min
  localparam longint      TENTH_MIN_NS = 64'd6_000_000_000;
  localparam longint      CLK_PERIOD_NS = 64'd100;
  localparam longint      TICK_CYCLES_DEF = TENTH_MIN_NS / CLK_PERIOD_NS;
  localparam int          HOUR_MIN     = 60;
  localparam int          ELAP_MIN     = 120;
  localparam logic [9:0]  HOUR_TICKS   = 10'(HOUR_MIN * 10);
  localparam logic [10:0] ELAP_SAT     = 11'(ELAP_MIN * 10);

  // register indices
  localparam logic [3:0]  REG_MAX      = 4'h0;
  localparam logic [3:0]  REG_IVL      = 4'h1;
  localparam logic [3:0]  REG_THRESH   = 4'h2;
  localparam logic [3:0]  REG_NOMINAL  = 4'h3;
  localparam logic [3:0]  REG_STATUS   = 4'h4;
  localparam logic [3:0]  REG_ELAPSED  = 4'h5;

  // status field positions
  localparam int          ST_RUN       = 8;
  localparam int          ST_INH       = 9;
  localparam int          ST_ALM       = 10;
  localparam int          ST_STRAP     = 11;

  // reset values
  localparam logic [4:0]  MAX_RST      = 5'h03;
  localparam logic [9:0]  IVL_RST      = 10'h000;
  localparam logic [15:0] THRESH_RST   = 16'h0200;
  localparam logic [15:0] NOMINAL_RST  = 16'h0100;
  localparam logic [1:0]  INIT_DONE    = 2'h3;   // strap taken at the third edge after reset

  typedef struct packed {
    logic [CUR_W-1:0] a;
    logic [CUR_W-1:0] b;
    logic [CUR_W-1:0] c;
  } mri_phase_t;

  typedef struct packed {
    logic                    strap_s1;
    logic                    strap_s2;
    logic [1:0]              init;
    logic                    strap;
    logic [31:0]             tick_cnt;
    logic                    armed;
    logic                    running;
    logic [SLOTS-1:0][9:0]   ages;
    logic [4:0]              wr_ptr;
    logic [10:0]             elapsed;
    logic [4:0]              max_starts;
    logic [9:0]              ivl_set;
    logic [CUR_W-1:0]        thresh;
    logic [CUR_W-1:0]        nominal;
    logic                    inhibit;
    logic                    alarm;
    logic [15:0]             rdata;
  } mri_state_t;

endpackage

// file: core/mri_top.sv
// motor restart inhibit: start detection, sliding hourly count, interval timer
`timescale 1ns/100ps
module mri_top #(
  parameter int unsigned TICK_CYCLES = 32'(mri_pkg::TICK_CYCLES_DEF)
) (
  input  wire logic               I_CORE_CLK,
  input  wire logic               I_RESET,
  input  wire mri_pkg::mri_phase_t I_PHASE,
  input  wire logic               I_DEF_ELAP_ZERO,
  input  wire logic [3:0]         I_ADDR,
  input  wire logic [15:0]        I_WDATA,
  input  wire logic               I_WR,
  input  wire logic               I_RD,
  output logic      [15:0]        O_RDATA,
  output logic                    O_INHIBIT,
  output logic                    O_ALARM,
  output logic                    O_RUNNING
);
  import mri_pkg::*;

  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  // the whole block state lives in one struct: one comb process builds the
  // next copy, one clocked process registers it, so nothing is half updated
  // limitation: phase magnitudes are taken unsynchronised; they must come
  // from logic on this clock, not straight from converter pins
  mri_state_t st;
  mri_state_t next_st;

  // number of starts still inside the one-hour window
  function automatic logic [4:0] live_count(input logic [SLOTS-1:0][9:0] ages);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < SLOTS; i++) begin
      if (ages[i] != 10'h000) begin
        n = n + 5'h01;
      end
    end
    return n;
  endfunction

  // largest of two magnitudes
  function automatic logic [CUR_W-1:0] maxof(input logic [CUR_W-1:0] x, input logic [CUR_W-1:0] y);
    return (x > y) ? x : y;
  endfunction

  logic [CUR_W-1:0] cur_max;
  logic [CUR_W+3:0] cur_x10;
  logic             cur_low;
  logic             start_ev;
  logic             tick;
  logic [4:0]       cnt;
  logic             ivl_active;

  // detection levels from the largest phase; x10 avoids a divider
  always_comb begin
    cur_max = maxof(maxof(I_PHASE.a, I_PHASE.b), I_PHASE.c);
    // low means max * (100 / PCT_LOW) < nominal, i.e. under PCT_LOW percent
    cur_x10 = (CUR_W+4)'(cur_max) * (CUR_W+4)'(100 / PCT_LOW);
    cur_low = cur_x10 < (CUR_W+4)'(st.nominal);
    start_ev = st.armed && !st.running && (cur_max > st.thresh);
    tick = st.tick_cnt == TICK_CYCLES - 1;
    cnt = live_count(st.ages);
    // a zero interval switches the interval check off
    ivl_active = (st.ivl_set != 10'h000) && (st.elapsed < {1'b0, st.ivl_set});
  end

  // whole next state
  always_comb begin
    next_st = st;
    // strap passes two flip-flops before it is read
    next_st.strap_s1 = I_DEF_ELAP_ZERO;
    next_st.strap_s2 = st.strap_s1;
    // strap caught once, after reset release, when the synchroniser has settled
    if (st.init != INIT_DONE) begin
      next_st.init = st.init + 2'h1;
      if (st.init == INIT_DONE - 2'h1) begin
        next_st.strap = st.strap_s2;
        next_st.elapsed = st.strap_s2 ? 11'h000 : ELAP_SAT;
      end
    end

    // timebase: one tick per tenth of a minute; ages and the elapsed counter
    // move on the same tick, so the hour and the interval stay aligned
    next_st.tick_cnt = tick ? 32'h0000_0000 : st.tick_cnt + 32'h0000_0001;
    if (tick) begin
      for (int i = 0; i < SLOTS; i++) begin
        if (st.ages[i] != 10'h000) begin
          next_st.ages[i] = st.ages[i] - 10'h001;
        end
      end
      if (st.elapsed < ELAP_SAT) begin
        next_st.elapsed = st.elapsed + 11'h001;
      end
    end

    // arming needs low current seen while stopped, so a running motor at
    // power-up is not miscounted as a fresh start
    if (!st.running && cur_low) begin
      next_st.armed = 1'b1;
    end
    if (start_ev) begin
      next_st.running = 1'b1;
      next_st.armed = 1'b0;
      // oldest slot is overwritten; in a full ring it is the one nearest expiry
      next_st.ages[st.wr_ptr] = HOUR_TICKS;
      next_st.wr_ptr = (st.wr_ptr == 5'(SLOTS - 1)) ? 5'h00 : st.wr_ptr + 5'h01;
      next_st.elapsed = 11'h000;
    end else if (st.running && cur_low) begin
      next_st.running = 1'b0;
    end

    // outputs, one cycle behind the count and elapsed values they follow;
    // a start past the limit is still counted, the inhibit is only advisory
    next_st.inhibit = (cnt >= st.max_starts) || ivl_active;
    next_st.alarm = (cnt != 5'h00) && (cnt == st.max_starts - 5'h01);

    // single settings set; out-of-range writes are dropped whole
    if (I_WR) begin
      case (I_ADDR)
        REG_MAX: begin
          if (I_WDATA[4:0] >= MAX_LO && I_WDATA[4:0] <= MAX_HI && I_WDATA[15:5] == 11'h000) begin
            next_st.max_starts = I_WDATA[4:0];
          end
        end
        REG_IVL: begin
          if (I_WDATA[9:0] <= IVL_HI && I_WDATA[15:10] == 6'h00) begin
            next_st.ivl_set = I_WDATA[9:0];
          end
        end
        REG_THRESH:  next_st.thresh = I_WDATA;
        REG_NOMINAL: next_st.nominal = I_WDATA;
        default: begin
        end
      endcase
    end

    // read data valid in the cycle after the strobe only
    next_st.rdata = 16'h0000;
    if (I_RD) begin
      case (I_ADDR)
        REG_MAX:     next_st.rdata = {11'h000, st.max_starts};
        REG_IVL:     next_st.rdata = {6'h00, st.ivl_set};
        REG_THRESH:  next_st.rdata = st.thresh;
        REG_NOMINAL: next_st.rdata = st.nominal;
        REG_STATUS: begin
          next_st.rdata[4:0] = cnt;
          next_st.rdata[ST_RUN] = st.running;
          next_st.rdata[ST_INH] = st.inhibit;
          next_st.rdata[ST_ALM] = st.alarm;
          next_st.rdata[ST_STRAP] = st.strap;
        end
        REG_ELAPSED: next_st.rdata = {5'h00, st.elapsed};
        default:     next_st.rdata = 16'h0000;
      endcase
    end
  end

  // state register
  // synchronous reset; settings return to defaults and all ages are cleared
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      next_st_reset: begin
        st <= '0;
        st.elapsed <= ELAP_SAT;
        st.max_starts <= MAX_RST;
        st.ivl_set <= IVL_RST;
        st.thresh <= THRESH_RST;
        st.nominal <= NOMINAL_RST;
      end
    end else begin
      st <= next_st;
    end
  end

  assign O_RDATA = st.rdata;
  assign O_INHIBIT = st.inhibit;
  assign O_ALARM = st.alarm;
  assign O_RUNNING = st.running;

  // checks sample on the core clock and sleep through reset
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);

  property p_start_rise;
    $rose(st.running) |-> $past(st.armed) && $past(cur_max) > $past(st.thresh);
  endproperty
  a_start_rise: assert property (p_start_rise) else $error("start without arm or threshold");

  property p_stop;
    st.running && cur_low |=> !st.running;
  endproperty
  a_stop: assert property (p_stop) else $error("low current did not stop motor");

  property p_alarm;
    st.alarm |-> $past(cnt) != 5'h00 && $past(cnt) + 5'h01 == $past(st.max_starts);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm outside max minus one");

  property p_ivl_inhibit;
    start_ev && st.ivl_set != 10'h000 && !tick |-> ##2 st.inhibit;
  endproperty
  a_ivl_inhibit: assert property (p_ivl_inhibit) else $error("start gave no inhibit");

  property p_count_inhibit;
    cnt >= st.max_starts |=> st.inhibit;
  endproperty
  a_count_inhibit: assert property (p_count_inhibit) else $error("full count not inhibited");

  property p_max_range;
    st.max_starts >= MAX_LO && st.max_starts <= MAX_HI;
  endproperty
  a_max_range: assert property (p_max_range) else $error("max starts out of range");

  property p_ivl_range;
    st.ivl_set <= IVL_HI;
  endproperty
  a_ivl_range: assert property (p_ivl_range) else $error("interval out of range");

  property p_ivl_off;
    st.ivl_set == 10'h000 && cnt < st.max_starts |=> !st.inhibit;
  endproperty
  a_ivl_off: assert property (p_ivl_off) else $error("inhibit with interval off");

  property p_count_up;
    start_ev && cnt < 5'(SLOTS) && !tick |=> cnt == $past(cnt) + 5'h01;
  endproperty
  a_count_up: assert property (p_count_up) else $error("start not counted");

  // motor stays running while the current is above the low level
  property p_run_hold;
    st.running && !cur_low |=> st.running;
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("stop above low level");

  // early warning follows the count one cycle later
  property p_alarm_set;
    cnt != 5'h00 && cnt == st.max_starts - 5'h01 |=> st.alarm;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm missing");

  property p_alarm_clear;
    cnt == st.max_starts |=> !st.alarm;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("alarm at full count");

  // interval inhibit drops once elapsed has caught up with the setting
  property p_ivl_release;
    st.ivl_set != 10'h000 && st.elapsed >= {1'b0, st.ivl_set} && cnt < st.max_starts
      |=> !st.inhibit;
  endproperty
  a_ivl_release: assert property (p_ivl_release) else $error("inhibit past interval");

  // strap value comes from the second synchroniser stage only
  property p_strap_cap;
    st.init == INIT_DONE - 2'h1 |=> st.strap == $past(st.strap_s2);
  endproperty
  a_strap_cap: assert property (p_strap_cap) else $error("strap not captured");

  property p_elap_sat;
    st.elapsed <= ELAP_SAT;
  endproperty
  a_elap_sat: assert property (p_elap_sat) else $error("elapsed too large");

  // settings and bus checks
  property p_ivl_write;
    I_WR && I_ADDR == REG_IVL && I_WDATA <= {6'h00, IVL_HI}
      |=> st.ivl_set == $past(I_WDATA[9:0]);
  endproperty
  a_ivl_write: assert property (p_ivl_write) else $error("interval write lost");

  property p_thresh_write;
    I_WR && I_ADDR == REG_THRESH |=> st.thresh == $past(I_WDATA);
  endproperty
  a_thresh_write: assert property (p_thresh_write) else $error("threshold write lost");

  // read data stand for one cycle only, zero otherwise
  property p_rdata_idle;
    !$past(I_RD) |-> st.rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  property p_wr_ptr_range;
    st.wr_ptr < 5'(SLOTS);
  endproperty
  a_wr_ptr_range: assert property (p_wr_ptr_range) else $error("bad slot index");

  // without a start, a tick can only age starts out
  property p_count_down;
    tick && !start_ev |=> cnt <= $past(cnt);
  endproperty
  a_count_down: assert property (p_count_down) else $error("count rose on tick");

  property p_tick_range;
    st.tick_cnt < TICK_CYCLES;
  endproperty
  a_tick_range: assert property (p_tick_range) else $error("tick count too large");

  // main scenarios: start and stop, full count, release, strap, age-out
  c_start: cover property (start_ev ##[1:1000] (st.running && cur_low));
  c_full: cover property (st.alarm ##[1:1000] (cnt == st.max_starts));
  c_release: cover property ($fell(st.inhibit));
  c_strap: cover property (st.init == INIT_DONE - 2'h1 && st.strap_s2);
  c_alarm_age: cover property ($fell(st.alarm) && cnt < st.max_starts - 5'h01);

endmodule

// file: sim/mri_motor.sv
// partner model: three phase current magnitudes of the motor
`timescale 1ns/100ps
module mri_motor (
  input  wire logic           i_clk,
  input  wire logic [1:0]     i_level,
  input  wire logic [1:0]     i_pick,
  input  wire logic [15:0]    i_noise,
  output mri_pkg::mri_phase_t o_phase
);
  import mri_pkg::*;
  logic [15:0] mag;
  // 0 stopped (under 10% of nominal), 1 running, 2 inrush above threshold
  always_comb begin
    case (i_level)
      2'h0: mag = i_noise % 16'h0019;
      2'h1: mag = 16'h0080 + {8'h00, i_noise[7:0]};
      default: mag = 16'h0201 + {6'h00, i_noise[9:0]};
    endcase
  end
  // largest phase wanders, so detection must take the maximum
  always_ff @(posedge i_clk) begin
    o_phase.a <= (i_pick == 2'h0) ? mag : mag >> 1;
    o_phase.b <= (i_pick == 2'h1) ? mag : mag >> 1;
    o_phase.c <= (i_pick[1]) ? mag : mag >> 1;
  end
endmodule

// file: sim/motor_restart_inhibit_test.sv
// testbench of the motor restart inhibit block
`timescale 1ns/100ps
module motor_restart_inhibit_test;
  import mri_pkg::*;
  localparam int TC = 4;
  logic        clk, rst, strap, wr, rd, rd_q, inh, alm, run;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, noise;
  logic [1:0]  level, pick;
  mri_phase_t  phase;
  logic [15:0] exq[$];
  int          err_total, checked, cyc, c1, c2, seed;

  // free running clock, 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  mri_top #(.TICK_CYCLES(TC)) dut (.I_CORE_CLK(clk), .I_RESET(rst), .I_PHASE(phase),
    .I_DEF_ELAP_ZERO(strap), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .O_INHIBIT(inh), .O_ALARM(alm), .O_RUNNING(run));
  mri_motor partner (.i_clk(clk), .i_level(level), .i_pick(pick), .i_noise(noise),
    .o_phase(phase));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // random phase spread; read data is only valid the cycle after the strobe
  always @(posedge clk) begin
    pick <= 2'($random(seed));
    noise <= 16'($random(seed));
    cyc <= cyc + 1;
    rd_q <= rd;
    if (rd_q) check(rdata, exq.pop_front());
  end

  task automatic wrr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    exq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // outputs seen directly, then again through the status word
  task automatic stat(input logic [4:0] n, input logic r, i, al, s);
    @(negedge clk);
    check({13'h0, alm, inh, run}, {13'h0, al, i, r});
    rdr(REG_STATUS, {4'h0, s, al, i, r, 3'h0, n});
  endtask

  task automatic go(input logic [1:0] l, input int n);
    @(posedge clk);
    level <= l;
    repeat (n) @(posedge clk);
  endtask

  // a start needs a low spell first, then inrush
  task automatic mstart();
    go(2'h0, 4);
    go(2'h2, 6);
    go(2'h1, 4);
  endtask

  initial begin
    #2000000;
    err_total++;
    finish_test();
  end

  initial begin
    {seed, err_total, checked} = {32'd19, 32'd0, 32'd0};
    {rst, strap, wr, rd, addr, wdata, level} = {1'b1, 25'h0};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rdr(REG_MAX, 16'h0003);
    rdr(REG_IVL, 16'h0000);
    rdr(REG_THRESH, 16'h0200);
    rdr(REG_NOMINAL, 16'h0100);
    rdr(4'hF, 16'h0000);
    rdr(REG_ELAPSED, 16'h04B0);
    wrr(REG_MAX, 16'h0000);
    wrr(REG_MAX, 16'h0015);
    rdr(REG_MAX, 16'h0003);
    wrr(REG_MAX, 16'h0014);
    rdr(REG_MAX, 16'h0014);
    wrr(REG_MAX, 16'h0001);
    rdr(REG_MAX, 16'h0001);
    wrr(REG_IVL, 16'h03E9);
    rdr(REG_IVL, 16'h0000);
    wrr(REG_IVL, 16'h03E8);
    rdr(REG_IVL, 16'h03E8);
    stat(5'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    wrr(REG_MAX, 16'h0003);
    wrr(REG_IVL, 16'h0005);
    mstart();
    c1 = cyc;
    stat(5'h01, 1'b1, 1'b1, 1'b0, 1'b0);
    repeat (24) @(posedge clk);
    stat(5'h01, 1'b1, 1'b0, 1'b0, 1'b0);
    go(2'h2, 6);
    go(2'h1, 4);
    stat(5'h01, 1'b1, 1'b0, 1'b0, 1'b0);
    go(2'h0, 4);
    stat(5'h01, 1'b0, 1'b0, 1'b0, 1'b0);
    wrr(REG_IVL, 16'h0000);
    while (cyc < c1 + 1200) @(posedge clk);
    mstart();
    c2 = cyc;
    stat(5'h02, 1'b1, 1'b0, 1'b1, 1'b0);
    mstart();
    stat(5'h03, 1'b1, 1'b1, 1'b0, 1'b0);
    while (cyc < c1 + 2360) @(posedge clk);
    stat(5'h03, 1'b1, 1'b1, 1'b0, 1'b0);
    while (cyc < c1 + 2440) @(posedge clk);
    stat(5'h02, 1'b1, 1'b0, 1'b1, 1'b0);
    while (cyc < c2 + 2480) @(posedge clk);
    stat(5'h00, 1'b1, 1'b0, 1'b0, 1'b0);
    // second power-up with the zero elapsed strap
    @(posedge clk);
    rst <= 1'b1;
    strap <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    wrr(REG_IVL, 16'h0005);
    // inhibit follows the new interval one cycle after the write lands
    @(posedge clk);
    stat(5'h00, 1'b0, 1'b1, 1'b0, 1'b1);
    repeat (24) @(posedge clk);
    stat(5'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule
